/* include/i2mt_defs.svh */
`ifndef I2MT_DEFS_SVH
`define I2MT_DEFS_SVH

// register indices on the plain port
`define A_CTRL1 3'h0
`define A_CTRL2 3'h1
`define A_MODE 3'h2
`define A_IEN 3'h3
`define A_STAT 3'h4
`define A_TXD 3'h5
`define A_SAR 3'h6

// control register one fields
`define BIT_IF_EN 7
`define BIT_MASTER 5
`define BIT_XMIT 4
`define CKS_HI 3
`define CKS_LO 0
// control register two fields
`define BIT_BUSY 7
`define BIT_SSC 6
// mode register fields
`define BIT_ORDER 3
`define BIT_WAIT 2
// enable register fields
`define BIT_ACK_CHK 2
`define BIT_RX_ACK 0
// status register fields
`define BIT_TX_EMPTY 7
`define BIT_TX_END 6
`define BIT_NO_ACK 4
`define BIT_STOP_DET 3
// own address field
`define SAR_HI 7
`define SAR_LO 1

// flag vector indices
`define F_NACK 0
`define F_STOP 1
`define F_TX_END_FLAG 2
`define NFLAG 3

// reset values and constants
`define BYTE_ZERO 8'h00
`define SAR_RST 7'h00
`define GEN_CALL 7'h00
`define LAST_BIT 3'h7
`define HALF_SHIFT 2
`define CNT_ONE 8'h01

`endif

/* include/i2mt_pkg.sv */
package i2mt_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_START = 4'h1,
        ST_HOLD = 4'h2,
        ST_BIT_LOW = 4'h3,
        ST_BIT_HIGH = 4'h4,
        ST_ACK_LOW = 4'h5,
        ST_ACK_HIGH = 4'h6,
        ST_STOP_LOW = 4'h7,
        ST_STOP_HIGH = 4'h8
    } i2mt_state_e;

    typedef logic [7:0] i2mt_byte_t;

endpackage : i2mt_pkg

/* src/i2mt_sync.sv */
`timescale 1ns/1ns
module i2mt_sync
    import i2mt_pkg::*;
#(
    parameter int WIDTH = 2
)
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // levels from outside
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] idle_level,
    // synchronised levels
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clock)
            begin
                if (reset)
                begin
                    meta_reg[i] <= 1'b1;
                    sync_out[i] <= 1'b1;
                end
                else
                begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i] & idle_level[i];
                end
            end
        end
    endgenerate

endmodule : i2mt_sync

/* src/i2mt_tick.sv */
`timescale 1ns/1ns
`include "i2mt_defs.svh"
module i2mt_tick
    import i2mt_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // rate select
    input wire logic [3:0] sel,
    // one pulse per half bit period
    output logic tick
);

    logic [7:0] count_reg;
    logic [7:0] limit;

    // half period is (sel + 1) * 4 cycles of the system clock
    assign limit = 8'((({4'h0, sel}) + `CNT_ONE) << `HALF_SHIFT);

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            count_reg <= `BYTE_ZERO;
            tick <= 1'b0;
        end
        else if (count_reg >= 8'(limit - `CNT_ONE))
        begin
            count_reg <= `BYTE_ZERO;
            tick <= 1'b1;
        end
        else
        begin
            count_reg <= 8'(count_reg + `CNT_ONE);
            tick <= 1'b0;
        end
    end

endmodule : i2mt_tick

/* src/i2mt_top.sv */
`timescale 1ns/1ns
`include "i2mt_defs.svh"
// How it works
// - no-ack flag sets when slave withholds ack and ack check is on
// - no-ack flag clears by writing 0 after reading it as 1
// - master: stop seen on bus after a frame sets stop flag
// - slave: stop sets flag only after own or general call address matched
// - stop flag clears by writing 0 after reading it as 1
// - direction bit 1 means slave to master, 0 master to slave
// - stop is sda rising while scl stays high
// - master drives clock and data; slave acks each byte
// - busy 1 with start/stop control 0 in one write issues start
// - data write clears empty, byte moves to shifter, empty sets again
// - byte done with empty set raises transmit end at end of ninth clock high, as scl is pulled low
// - received ack bit holds slave ack; 1 means stop should follow
// - busy 0 with start/stop control 0 in one write issues stop
// - scl held low until next byte or stop request
// - stop flag after master transfer returns device to slave receive
module i2mt_top
    import i2mt_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // serial clock pin
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // serial data pin
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);

    i2mt_state_e state_reg, state_next;
    logic if_en_reg, master_reg, xmit_reg, order_reg, wait_reg, ack_chk_reg;
    logic [3:0] cks_reg;
    logic [6:0] sar_reg;
    i2mt_byte_t txd_reg, shift_reg;
    logic [2:0] bit_cnt_reg;
    logic tx_empty_reg, rx_ack_reg, bus_busy_reg, frame_reg;
    logic start_pend_reg, stop_pend_reg;
    logic [`NFLAG-1:0] flag_reg, arm_reg, flag_set, flag_clr_hw;
    logic scl_s, sda_s, scl_d, sda_d;
    logic tick;
    logic wr_ctrl2, wr_txd, wr_stat;
    logic ev_load, ev_ack, start_det, stop_det, scl_rise;
    logic collect_reg, match_reg;
    logic [2:0] slv_cnt_reg;
    logic [6:0] slv_sh_reg;
    logic out_bit;

    // pins pass two flops before anything looks at them
    i2mt_sync #(.WIDTH(2)) u_sync (
        .clock(clock),
        .reset(reset),
        .async_in({scl_in, sda_in}),
        .idle_level(2'b11),
        .sync_out({scl_s, sda_s})
    );

    i2mt_tick u_tick (
        .clock(clock),
        .reset(reset),
        .sel(cks_reg),
        .tick(tick)
    );

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det = scl_s && scl_d && !sda_d && sda_s;
    assign scl_rise = scl_s && !scl_d;

    assign wr_ctrl2 = reg_write && (reg_addr == `A_CTRL2);
    assign wr_txd = reg_write && (reg_addr == `A_TXD);
    assign wr_stat = reg_write && (reg_addr == `A_STAT);

    // plain configuration registers
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            if_en_reg <= 1'b0;
            cks_reg <= 4'h0;
            order_reg <= 1'b0;
            wait_reg <= 1'b0;
            ack_chk_reg <= 1'b0;
            sar_reg <= `SAR_RST;
            txd_reg <= `BYTE_ZERO;
        end
        else if (reg_write)
        begin
            unique case (reg_addr)
                `A_CTRL1:
                begin
                    if_en_reg <= reg_wdata[`BIT_IF_EN];
                    cks_reg <= reg_wdata[`CKS_HI:`CKS_LO];
                end
                `A_MODE:
                begin
                    order_reg <= reg_wdata[`BIT_ORDER];
                    wait_reg <= reg_wdata[`BIT_WAIT];
                end
                `A_IEN: ack_chk_reg <= reg_wdata[`BIT_ACK_CHK];
                `A_SAR: sar_reg <= reg_wdata[`SAR_HI:`SAR_LO];
                `A_TXD: txd_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // mode bits; a stop after our own frame drops back to slave receive
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            master_reg <= 1'b0;
            xmit_reg <= 1'b0;
        end
        else if (master_reg && frame_reg && stop_det)
        begin
            master_reg <= 1'b0;
            xmit_reg <= 1'b0;
        end
        else if (reg_write && reg_addr == `A_CTRL1)
        begin
            master_reg <= reg_wdata[`BIT_MASTER];
            xmit_reg <= reg_wdata[`BIT_XMIT];
        end
    end

    // start and stop requests wait for the engine to take them
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            start_pend_reg <= 1'b0;
            stop_pend_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctrl2 && reg_wdata[`BIT_BUSY] && !reg_wdata[`BIT_SSC] && if_en_reg
                && master_reg && xmit_reg && !bus_busy_reg && state_reg == ST_IDLE)
                start_pend_reg <= 1'b1;
            else if (state_reg == ST_START)
                start_pend_reg <= 1'b0;
            if (wr_ctrl2 && !reg_wdata[`BIT_BUSY] && !reg_wdata[`BIT_SSC]
                && state_reg != ST_IDLE)
                stop_pend_reg <= 1'b1;
            else if (state_reg == ST_STOP_LOW)
                stop_pend_reg <= 1'b0;
        end
    end

    // line activity seen on the pins, plus our own pending start
    always_ff @(posedge clock)
    begin
        if (reset)
            bus_busy_reg <= 1'b0;
        else if (start_det || start_pend_reg)
            bus_busy_reg <= 1'b1;
        else if (stop_det)
            bus_busy_reg <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            frame_reg <= 1'b0;
        else if (stop_det)
            frame_reg <= 1'b0;
        else if (start_det && master_reg)
            frame_reg <= 1'b1;
    end

    // slave side address watch, used only to qualify a stop
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            collect_reg <= 1'b0;
            match_reg <= 1'b0;
            slv_cnt_reg <= 3'h0;
            slv_sh_reg <= `SAR_RST;
        end
        else if (start_det)
        begin
            collect_reg <= 1'b1;
            match_reg <= 1'b0;
            slv_cnt_reg <= 3'h0;
        end
        else if (stop_det)
        begin
            collect_reg <= 1'b0;
            match_reg <= 1'b0;
        end
        else if (collect_reg && scl_rise)
        begin
            slv_sh_reg <= {slv_sh_reg[5:0], sda_s};
            slv_cnt_reg <= 3'(slv_cnt_reg + 3'h1);
            if (slv_cnt_reg == `LAST_BIT)
            begin
                // eighth bit is direction; the seven before it are the address
                collect_reg <= 1'b0;
                match_reg <= (slv_sh_reg == sar_reg) || (slv_sh_reg == `GEN_CALL);
            end
        end
    end

    // bit order: zero sends msb first
    assign out_bit = order_reg ? shift_reg[0] : shift_reg[7];

    always_comb
    begin
        state_next = state_reg;
        ev_load = 1'b0;
        ev_ack = 1'b0;
        unique case (state_reg)
            ST_IDLE:
                if (start_pend_reg && tick)
                    state_next = ST_START;
            ST_START:
                if (tick)
                    state_next = ST_HOLD;
            ST_HOLD:
                // scl stays low here; no timeout, software owns the pace
                if (stop_pend_reg && tick)
                    state_next = ST_STOP_LOW;
                else if (!tx_empty_reg && !stop_pend_reg && tick)
                begin
                    ev_load = 1'b1;
                    state_next = ST_BIT_LOW;
                end
            ST_BIT_LOW:
                if (tick)
                    state_next = ST_BIT_HIGH;
            ST_BIT_HIGH:
                if (tick && scl_s)
                    state_next = (bit_cnt_reg == `LAST_BIT) ? ST_ACK_LOW : ST_BIT_LOW;
            ST_ACK_LOW:
                if (tick)
                    state_next = ST_ACK_HIGH;
            ST_ACK_HIGH:
                if (tick && scl_s)
                begin
                    ev_ack = 1'b1;
                    if (tx_empty_reg || stop_pend_reg || (sda_s && ack_chk_reg))
                        state_next = ST_HOLD;
                    else
                    begin
                        ev_load = 1'b1;
                        state_next = ST_BIT_LOW;
                    end
                end
            ST_STOP_LOW:
                if (tick)
                    state_next = ST_STOP_HIGH;
            ST_STOP_HIGH:
                if (tick && scl_s)
                    state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // shifter and bit counter; the first byte carries address and direction
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            shift_reg <= `BYTE_ZERO;
            bit_cnt_reg <= 3'h0;
        end
        else if (ev_load)
        begin
            shift_reg <= txd_reg;
            bit_cnt_reg <= 3'h0;
        end
        else if (state_reg == ST_BIT_HIGH && state_next != ST_BIT_HIGH)
        begin
            shift_reg <= order_reg ? {1'b0, shift_reg[7:1]} : {shift_reg[6:0], 1'b0};
            bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
        end
    end

    // drive from the next state; data moves a cycle after scl falls, never with it
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            unique case (state_next)
                ST_IDLE, ST_START, ST_BIT_HIGH, ST_ACK_HIGH, ST_STOP_HIGH: scl_oe <= 1'b0;
                default: scl_oe <= 1'b1;
            endcase
            unique case (state_next)
                ST_IDLE, ST_ACK_HIGH: sda_oe <= 1'b0;
                ST_ACK_LOW: sda_oe <= (state_reg == ST_ACK_LOW) ? 1'b0 : sda_oe;
                ST_BIT_LOW: sda_oe <= (state_reg == ST_BIT_LOW) ? !out_bit : sda_oe;
                ST_HOLD: sda_oe <= (state_reg == ST_HOLD) ? 1'b1 : sda_oe;
                ST_BIT_HIGH: sda_oe <= sda_oe;
                default: sda_oe <= 1'b1;
            endcase
        end
    end

    // an open drain only ever pulls low
    always_ff @(posedge clock)
    begin
        scl_out <= 1'b0;
        sda_out <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            rx_ack_reg <= 1'b0;
        else if (ev_ack)
            rx_ack_reg <= sda_s;
    end

    // transmit data empty: cleared by a data write, set when shifter takes it
    always_ff @(posedge clock)
    begin
        if (reset)
            tx_empty_reg <= 1'b1;
        else if (ev_load)
            tx_empty_reg <= 1'b1;
        else if (wr_txd)
            tx_empty_reg <= 1'b0;
    end

    assign flag_set[`F_NACK] = ev_ack && sda_s && ack_chk_reg;
    assign flag_set[`F_STOP] = stop_det && ((master_reg && frame_reg) || (!master_reg && match_reg));
    assign flag_set[`F_TX_END_FLAG] = ev_ack && tx_empty_reg;
    assign flag_clr_hw[`F_NACK] = 1'b0;
    assign flag_clr_hw[`F_STOP] = 1'b0;
    assign flag_clr_hw[`F_TX_END_FLAG] = wr_txd;

    // write-zero-after-read-one flags; a set in the same cycle wins
    genvar f;
    generate
        for (f = 0; f < `NFLAG; f++)
        begin : g_flag
            logic wbit;
            assign wbit = (f == `F_NACK) ? reg_wdata[`BIT_NO_ACK]
                : (f == `F_STOP) ? reg_wdata[`BIT_STOP_DET] : reg_wdata[`BIT_TX_END];
            always_ff @(posedge clock)
            begin
                if (reset)
                begin
                    flag_reg[f] <= 1'b0;
                    arm_reg[f] <= 1'b0;
                end
                else
                begin
                    if (flag_set[f])
                        flag_reg[f] <= 1'b1;
                    else if ((wr_stat && !wbit && arm_reg[f]) || flag_clr_hw[f])
                        flag_reg[f] <= 1'b0;
                    if (reg_read && reg_addr == `A_STAT && flag_reg[f])
                        arm_reg[f] <= 1'b1;
                    else if (wr_stat || !flag_reg[f])
                        arm_reg[f] <= 1'b0;
                end
            end
        end
    endgenerate

    // read data stand in the cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (reset)
            reg_rdata <= `BYTE_ZERO;
        else if (reg_read)
        begin
            reg_rdata <= `BYTE_ZERO;
            unique case (reg_addr)
                `A_CTRL1:
                begin
                    reg_rdata[`BIT_IF_EN] <= if_en_reg;
                    reg_rdata[`BIT_MASTER] <= master_reg;
                    reg_rdata[`BIT_XMIT] <= xmit_reg;
                    reg_rdata[`CKS_HI:`CKS_LO] <= cks_reg;
                end
                `A_CTRL2: reg_rdata[`BIT_BUSY] <= bus_busy_reg;
                `A_MODE:
                begin
                    reg_rdata[`BIT_ORDER] <= order_reg;
                    reg_rdata[`BIT_WAIT] <= wait_reg;
                end
                `A_IEN:
                begin
                    reg_rdata[`BIT_ACK_CHK] <= ack_chk_reg;
                    reg_rdata[`BIT_RX_ACK] <= rx_ack_reg;
                end
                `A_STAT:
                begin
                    reg_rdata[`BIT_TX_EMPTY] <= tx_empty_reg;
                    reg_rdata[`BIT_TX_END] <= flag_reg[`F_TX_END_FLAG];
                    reg_rdata[`BIT_NO_ACK] <= flag_reg[`F_NACK];
                    reg_rdata[`BIT_STOP_DET] <= flag_reg[`F_STOP];
                end
                `A_TXD: reg_rdata <= txd_reg;
                `A_SAR: reg_rdata[`SAR_HI:`SAR_LO] <= sar_reg;
                default: ;
            endcase
        end
    end

endmodule : i2mt_top

/* bench/i2mt_checker_assertions.sv */
`timescale 1ns/1ns
`include "i2mt_defs.svh"
module i2mt_checker
    import i2mt_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // pin enables
    input wire logic scl_oe,
    input wire logic sda_oe
);
    logic rd_stat_reg;
    logic sda_prev_reg;
    logic nack_reg;
    logic stop_reg;
    logic armed_reg;
    logic [3:0] age_reg;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    always_ff @(posedge clock)
    begin
        sda_prev_reg <= sda_oe;
        rd_stat_reg <= reg_read && reg_addr == `A_STAT && !reset;
    end
    // flags seen as 1 stay 1 until a status write
    always_ff @(posedge clock)
    begin
        if (reset || (reg_write && reg_addr == `A_STAT))
        begin
            nack_reg <= 1'b0;
            stop_reg <= 1'b0;
        end
        else if (rd_stat_reg)
        begin
            nack_reg <= reg_rdata[`BIT_NO_ACK];
            stop_reg <= reg_rdata[`BIT_STOP_DET];
        end
    end
    // age since own stop; margin covers the pin synchroniser
    always_ff @(posedge clock)
    begin
        if (reset || (reg_write && reg_addr == `A_CTRL1))
        begin
            armed_reg <= 1'b0;
            age_reg <= 4'h0;
        end
        else if (sda_prev_reg && !sda_oe && !scl_oe)
        begin
            armed_reg <= 1'b1;
            age_reg <= 4'h0;
        end
        else if (age_reg != 4'hF)
            age_reg <= age_reg + 4'h1;
    end
    property p_unmapped;
        reg_read && reg_addr == 3'h7 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rdata_hold;
        !reg_read |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_scl_low;
        $rose(scl_oe) |=> scl_oe [*3];
    endproperty
    a_scl_low: assert property (p_scl_low) else $error("clock low too short");
    property p_sda_late;
        $changed(sda_oe) && scl_oe |-> $past(scl_oe);
    endproperty
    a_sda_late: assert property (p_sda_late) else $error("data raced clock");
    property p_start;
        $rose(sda_oe) && !scl_oe |-> !scl_oe [*4];
    endproperty
    a_start: assert property (p_start) else $error("start too short");
    property p_stop;
        $fell(sda_oe) && !scl_oe |-> !$past(scl_oe) && !$past(scl_oe, 4);
    endproperty
    a_stop: assert property (p_stop) else $error("stop without clock high");
    property p_nack_keep;
        reg_read && reg_addr == `A_STAT && nack_reg |=> reg_rdata[`BIT_NO_ACK];
    endproperty
    a_nack_keep: assert property (p_nack_keep) else $error("no-ack lost");
    property p_stop_keep;
        reg_read && reg_addr == `A_STAT && stop_reg |=> reg_rdata[`BIT_STOP_DET];
    endproperty
    a_stop_keep: assert property (p_stop_keep) else $error("stop flag lost");
    property p_master_back;
        reg_read && reg_addr == `A_CTRL1 && armed_reg && age_reg == 4'hF |=> !reg_rdata[5];
    endproperty
    a_master_back: assert property (p_master_back) else $error("master after stop");
    c_start: cover property ($rose(sda_oe) && !scl_oe);
    c_nack: cover property (nack_reg);
    c_back: cover property (armed_reg && age_reg == 4'hF);
endmodule : i2mt_checker

/* bench/i2mt_slave_model.sv */
`timescale 1ns/1ns
module i2mt_slave_model
(
    // bus wires
    input wire logic scl,
    input wire logic sda,
    // behaviour
    input wire logic refuse,
    input wire logic slow,
    // pulls and results
    output logic scl_oe,
    output logic sda_oe,
    output logic [7:0] got,
    output logic stopped
);
    int cnt;
    logic [7:0] sh;
    initial
    begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
        got = 8'h00;
        stopped = 1'b0;
        cnt = 0;
        sh = 8'h00;
    end
    // data moving with clock high frames a start or stop
    always @(sda)
        if (scl)
        begin
            cnt = 0;
            stopped = sda;
        end
    always @(posedge scl)
        if (cnt < 8)
        begin
            sh = {sh[6:0], sda};
            cnt = cnt + 1;
            if (cnt == 8)
                got = sh;
        end
    // ack each byte unless refusing
    always @(negedge scl)
        if (cnt == 8)
        begin
            sda_oe = !refuse;
            cnt = 9;
        end
        else if (cnt == 9)
        begin
            sda_oe = 1'b0;
            cnt = 0;
        end
        else if (slow && cnt == 4)
        begin
            scl_oe = 1'b1;
            #1000 scl_oe = 1'b0;
        end
endmodule : i2mt_slave_model

/* bench/i2c_master_transmit_engine_tb.sv */
`timescale 1ns/1ns
`include "i2mt_defs.svh"
module i2c_master_transmit_engine_tb
    import i2mt_pkg::*;
;
    logic clock;
    logic reset;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_rdata;
    logic scl_oe;
    logic sda_oe;
    logic m_scl_oe;
    logic m_sda_oe;
    logic refuse;
    logic slow;
    logic stopped;
    logic [7:0] got;
    wire scl;
    wire sda;
    int errors;
    int num_checks;
    // open drain with pull-ups
    assign scl = !(scl_oe | m_scl_oe);
    assign sda = !(sda_oe | m_sda_oe);
    i2mt_top dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl),
        .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
    i2mt_slave_model u_slave (.scl(scl), .sda(sda), .refuse(refuse), .slow(slow),
        .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .got(got), .stopped(stopped));
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask : reg_rd
    // a long low phase means the engine waits on software
    task automatic wait_hold;
        int low;
        int n;
        low = 0;
        for (n = 0; n < 5000 && low < 40; n++)
        begin
            @(posedge clock);
            low = scl ? 0 : low + 1;
        end
        check({7'h00, low == 40}, 8'h01);
    endtask : wait_hold
    task automatic xfer(input logic [7:0] mode, input logic nak, input logic ie,
        input logic [7:0] b0, input logic [7:0] e0);
        logic [7:0] d;
        int n;
        refuse = nak;
        slow = !nak;
        reg_wr(`A_MODE, mode);
        reg_wr(`A_IEN, {5'h00, ie, 2'h0});
        reg_wr(`A_CTRL1, 8'hB0);
        reg_rd(`A_CTRL2, d);
        check(d & 8'hC0, 8'h00);
        reg_wr(`A_CTRL2, 8'h80);
        wait_hold;
        reg_rd(`A_CTRL2, d);
        check(d & 8'hC0, 8'h80);
        reg_wr(`A_TXD, b0);
        repeat (12) @(posedge clock);
        reg_rd(`A_STAT, d);
        check(d & 8'hC0, 8'h80);
        wait_hold;
        check(got, e0);
        reg_wr(`A_STAT, 8'h00);
        reg_rd(`A_STAT, d);
        check(d & 8'hD8, (nak && ie) ? 8'hD0 : 8'hC0);
        reg_rd(`A_IEN, d);
        check(d & 8'h01, {7'h00, nak});
        reg_rd(`A_CTRL2, d);
        check(d & 8'hC0, 8'h80);
        if (!nak)
        begin
            reg_wr(`A_TXD, 8'h5A);
            reg_rd(`A_STAT, d);
            check(d & 8'h40, 8'h00);
            wait_hold;
            check(got, 8'h5A);
            reg_rd(`A_STAT, d);
        end
        reg_wr(`A_STAT, 8'h00);
        reg_rd(`A_STAT, d);
        check(d & 8'h58, 8'h00);
        reg_wr(`A_CTRL2, 8'h00);
        d = 8'h00;
        for (n = 0; n < 200 && !d[`BIT_STOP_DET]; n++)
            reg_rd(`A_STAT, d);
        check(d & 8'h08, 8'h08);
        check({7'h00, stopped}, 8'h01);
        reg_rd(`A_CTRL1, d);
        check(d & 8'h30, 8'h00);
        reg_rd(`A_CTRL2, d);
        check(d & 8'hC0, 8'h00);
        reg_wr(`A_STAT, 8'h00);
        reg_rd(`A_STAT, d);
        check(d & 8'h08, 8'h00);
        $display("test done, mode %h refuse %b", mode, nak);
    endtask : xfer
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // generous: three transfers need well under this
    initial
    begin
        #2000000;
        errors++;
        give_verdict;
    end
    initial
    begin
        logic [7:0] d;
        errors = 0;
        num_checks = 0;
        reset = 1'b1;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        refuse = 1'b0;
        slow = 1'b0;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        reg_rd(`A_STAT, d);
        check(d & 8'hD8, 8'h80);
        reg_wr(3'h7, 8'hFF);
        reg_rd(3'h7, d);
        check(d, 8'h00);
        reg_wr(`A_SAR, 8'h5C);
        reg_rd(`A_SAR, d);
        check(d & 8'hFE, 8'h5C);
        $display("test done, register defaults");
        xfer(8'h00, 1'b0, 1'b1, 8'hA4, 8'hA4);
        xfer(8'h08, 1'b1, 1'b1, 8'h12, 8'h48);
        xfer(8'h00, 1'b1, 1'b0, 8'hA6, 8'hA6);
        give_verdict;
    end
endmodule : i2c_master_transmit_engine_tb
bind i2mt_top i2mt_checker u_chk (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .scl_oe(scl_oe), .sda_oe(sda_oe));
